/* hw/usb_dma_if_defines.vh */
// constants for the endpoint dma interface: offsets, fields, encodings, resets
// included by usb_dma_if.v only
`ifndef USB_DMA_IF_DEFINES_VH
`define USB_DMA_IF_DEFINES_VH
`define OFS_RX_UNLK      12'h854
`define OFS_TX_UNLK      12'h858
`define OFS_LINK_CTRL    12'h85c
`define OFS_EP_BASE      12'h800
`define OFS_EP_LAST      12'h824
`define OFS_DMA_STAT     12'h860
`define RST_RX_UNLK      16'h0000
`define RST_TX_UNLK      16'h0000
`define RST_LINK_CTRL    16'h0000
`define RST_EP           16'h0000
`define RX_UNLK_W        10
`define EP_ID_W          4
`define NUM_EP           10
`define STAT_DIS         2'h0
`define STAT_STALL       2'h1
`define STAT_NAK         2'h2
`define STAT_VALID       2'h3
`define TYPE_BULK        2'h0
`define TYPE_CTRL        2'h1
`define TYPE_ISO         2'h2
`define TYPE_INT         2'h3
`define EPF_STAT_RX_LSB  12
`define EPF_RXDONE       15
`define EPF_TYPE_LSB     9
`define EPF_KIND         8
`define EPF_TXDONE       7
`define EPF_STAT_TX_LSB  4
`define LK_TX_EN_BIT     0
`define LK_TX_EP_LSB     1
`define RX_LINKED_MODE_ENABLE_BIT     8
`define LK_RX_EP_LSB     9
`define UNLK_TX_EN_LSB   12
`define ANS_IGNORE       2'h0
`define ANS_STALL        2'h1
`define ANS_NAK          2'h2
`define ANS_ACCEPT       2'h3
`endif

/* hw/usb_dma_if.v */
// endpoint control/status and dma request logic between usb endpoints and a dma controller
// assumes one ahb-lite master, token events from the usb engine on clk_sys
//
// Notes on behaviour
// - rx state 00: out requests to the endpoint are silently ignored
// - rx state 01 answers stall, 10 answers nak
// - rx state 11: endpoint accepts reception requests
// - tx state 00: in requests to the endpoint are ignored
// - tx state 01 answers stall, 10 answers nak
// - tx state 11: endpoint serves transmission requests
// - type field: 00 bulk, 01 control, 10 iso, 11 interrupt
// - kind bit: double buffer on bulk, status-out on control, else unused
// - two independent dma channels, tx and rx, any of ten endpoints
// - linked mode: one endpoint, requests continue until the chain ends
// - linked mode: endpoint done flag cleared automatically, masked from global irq
// - linked endpoint never raises a transfer-done interrupt from its linked direction
// - unlinked: up to 3 tx endpoints, up to 10 rx endpoints
// - unlinked: one packet per dma transfer
// - unlinked: done flags neither masked nor cleared by hardware
// - rx unlinked enable bits 15:10 read zero
// - rx unlinked enable bits software rw, cleared by hardware on completion
// - rx linked enable set: unlinked enables have no effect
// - unlinked enable 0: no dma request for that endpoint
// - tx state bits: write 0 keeps, write 1 toggles
// - after good in or setup, hardware sets tx state to nak; the logic does so after a good in only, as it sees no setup on xfer
// - iso tx state unchanged by hardware after success
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`include "usb_dma_if_defines.vh"
//
// register map, byte offsets within the block
//   0x800..0x824  endpoint registers, one word per endpoint 0..9
//   0x854         rx unlinked dma enables, bits 9:0
//   0x858         tx unlinked select and endpoint ids
//   0x85c         linked mode control, tx and rx
//   0x860         dma status, read only
//   other         reads zero, writes dropped
//
// endpoint register fields
//   [15]     rx done, write 0 clears, write 1 keeps
//   [14]     reserved, reads zero
//   [13:12]  rx state, written directly
//   [11]     reserved, reads zero
//   [10:9]   endpoint type
//   [8]      kind bit
//   [7]      tx done, write 0 clears, write 1 keeps
//   [6]      reserved, reads zero
//   [5:4]    tx state, toggled by writing 1
//   [3:0]    endpoint address
//
// tx unlinked control fields
//   [13:12]  select: 0 off, 1..3 serve id 1..3
//   [11:8]   id 3
//   [7:4]    id 2
//   [3:0]    id 1
//   ids only take a write while the tx channel is idle
//
// linked control fields
//   [0]      tx linked enable
//   [4:1]    tx linked endpoint
//   [8]      rx linked enable
//   [12:9]   rx linked endpoint
//   other bits read zero
//
// dma status fields
//   [9] rx busy, [8] tx busy, [7:4] rx endpoint, [3:0] tx endpoint
//
// bus timing
//   zero wait states; hreadyout is tied high
//   read data registered at the address phase edge
//   write data taken at the edge that ends the data phase
//   back-to-back transfers accepted
//
// token timing
//   answer and its strobe one cycle after the token strobe
//   endpoints 10..15 get no strobe at all
//   tokens with the setup flag use the tx state
//
// dma timing
//   channel goes busy one edge after a ready packet is seen
//   request follows busy; linked mode also gates it with ready
//   unlinked busy ends on the last-word ack
//   linked busy ends on the chain terminal count
//   served endpoint is latched only while the channel is idle
//
// limitation: rx endpoints are served lowest first, one packet each,
//   so software sees completions in endpoint order, not arrival order
//
module usb_dma_if (
  input wire clk_sys, // system clock, 125 mhz
  input wire rst_n, // synchronous reset, active low
  input wire hsel, // ahb slave select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire [2:0] hsize, // ahb size
  input wire [31:0] hwdata, // ahb write data
  input wire hready, // ahb bus ready
  output wire hreadyout, // ahb slave ready
  output wire hresp, // ahb response, always okay
  output reg [31:0] hrdata, // ahb read data
  input wire tokStrobe, // usb token event, one-cycle pulse
  input wire tokIsIn, // 1: in token, 0: out token
  input wire tokSetup, // token is a setup
  input wire [3:0] tokEp, // endpoint of token
  input wire xferGood, // transaction ended correctly, pulse
  input wire xferIsIn, // direction of the good transaction
  input wire [3:0] xferEp, // endpoint of the good transaction
  output reg [1:0] tokAnswer, // ignore, stall, nak or accept
  output reg tokAnswerValid, // answer strobe, one cycle
  output reg doubleBufSel, // kind bit on bulk for answered endpoint
  output reg statusOutSel, // kind bit on control for answered endpoint
  input wire txPktReady, // tx packet ready for the mapped endpoint
  input wire rxPktReady, // rx packet ready for the mapped endpoint
  input wire txLastAck, // dma accepted last tx word, pulse
  input wire rxLastAck, // dma accepted last rx word, pulse
  input wire txChainDone, // tx descriptor chain done (terminal count)
  input wire rxChainDone, // rx descriptor chain done (terminal count)
  output wire txDmaReq, // tx channel request
  output wire rxDmaReq, // rx channel request
  output reg [3:0] txDmaEp, // endpoint served on tx channel
  output reg [3:0] rxDmaEp, // endpoint served on rx channel
  output wire globalTransferDoneIrq // global transfer-done interrupt
);
  localparam ST_IDLE = 2'b01;
  localparam ST_DATA = 2'b10;

  reg [1:0] stateQ;
  reg [11:0] addrQ;
  reg writeQ;
  reg [15:0] epRegQ [0:`NUM_EP-1];
  reg [`RX_UNLK_W-1:0] rxUnlinkedDmaEnablesQ;
  reg [15:0] txUnlkQ;
  reg [15:0] linkCtrlQ;
  reg txBusyQ;
  reg rxBusyQ;
  wire txLinkedModeEnable;
  wire rxLinkedModeEnable;
  wire [3:0] txLinkedEp;
  wire [3:0] rxLinkedEp;
  wire [1:0] txUnlkSel;
  wire [3:0] txUnlkEp;
  wire [`NUM_EP-1:0] epWrite;
  wire [`NUM_EP-1:0] epIrq;
  wire addrPhase;
  wire [15:0] rxUnlkRst;
  integer i;

  function [1:0] answerOf;
    input [1:0] stat;
    begin
      case (stat)
        `STAT_DIS: answerOf = `ANS_IGNORE;
        `STAT_STALL: answerOf = `ANS_STALL;
        `STAT_NAK: answerOf = `ANS_NAK;
        default: answerOf = `ANS_ACCEPT;
      endcase
    end
  endfunction

  function [3:0] epIndex;
    input [11:0] a;
    begin
      epIndex = a[5:2];
    end
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel & hready & htrans[1];
  assign rxUnlkRst = `RST_RX_UNLK;

  assign txLinkedModeEnable = linkCtrlQ[`LK_TX_EN_BIT];
  assign rxLinkedModeEnable = linkCtrlQ[`RX_LINKED_MODE_ENABLE_BIT];
  assign txLinkedEp = linkCtrlQ[`LK_TX_EP_LSB +: 4];
  assign rxLinkedEp = linkCtrlQ[`LK_RX_EP_LSB +: 4];
  assign txUnlkSel = txUnlkQ[`UNLK_TX_EN_LSB +: 2];
  // three tx ids share one channel; the select picks which one is served
  assign txUnlkEp = (txUnlkSel == 2'h1) ? txUnlkQ[3:0] :
                    (txUnlkSel == 2'h2) ? txUnlkQ[7:4] : txUnlkQ[11:8];

  // bus state machine: one address phase, then a zero-wait data phase
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stateQ <= ST_IDLE;
      addrQ <= 12'h000;
      writeQ <= 1'b0;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          if (addrPhase) begin
            stateQ <= ST_DATA;
            addrQ <= haddr[11:0];
            writeQ <= hwrite;
          end
        end
        ST_DATA: begin
          if (addrPhase) begin
            addrQ <= haddr[11:0];
            writeQ <= hwrite;
          end else begin
            stateQ <= ST_IDLE;
          end
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  // endpoint registers, one per word from the endpoint base
  genvar g;
  generate
    for (g = 0; g < `NUM_EP; g = g + 1) begin : gEp
      wire swWr;
      wire hwTxGood;
      wire hwRxGood;
      wire isLinkedTx;
      wire isLinkedRx;
      wire [15:0] cur;
      assign cur = epRegQ[g];
      assign swWr = (stateQ == ST_DATA) & writeQ & (addrQ >= `OFS_EP_BASE) &
                    (addrQ <= `OFS_EP_LAST) & (epIndex(addrQ) == g);
      assign epWrite[g] = swWr;
      assign hwTxGood = xferGood & xferIsIn & (xferEp == g);
      assign hwRxGood = xferGood & ~xferIsIn & (xferEp == g);
      assign isLinkedTx = txLinkedModeEnable & (txLinkedEp == g);
      assign isLinkedRx = rxLinkedModeEnable & (rxLinkedEp == g);
      // the done flag of a linked direction never reaches the cpu interrupt
      assign epIrq[g] = (cur[`EPF_TXDONE] & ~isLinkedTx) |
                        (cur[`EPF_RXDONE] & ~isLinkedRx);
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          epRegQ[g] <= `RST_EP;
        end else begin : upd
          reg [15:0] nxt;
          nxt = cur;
          if (swWr) begin
            nxt[`EPF_TYPE_LSB +: 2] = hwdata[`EPF_TYPE_LSB +: 2];
            nxt[`EPF_KIND] = hwdata[`EPF_KIND];
            nxt[3:0] = hwdata[3:0];
            nxt[`EPF_STAT_TX_LSB +: 2] = cur[`EPF_STAT_TX_LSB +: 2] ^
                                         hwdata[`EPF_STAT_TX_LSB +: 2];
            nxt[`EPF_STAT_RX_LSB +: 2] = hwdata[`EPF_STAT_RX_LSB +: 2];
            // done flags are cleared by writing 0
            if (!hwdata[`EPF_TXDONE])
              nxt[`EPF_TXDONE] = 1'b0;
            if (!hwdata[`EPF_RXDONE])
              nxt[`EPF_RXDONE] = 1'b0;
          end
          if (hwTxGood) begin
            nxt[`EPF_TXDONE] = ~isLinkedTx; // set wins over clear
            if (cur[`EPF_TYPE_LSB +: 2] != `TYPE_ISO)
              nxt[`EPF_STAT_TX_LSB +: 2] = `STAT_NAK;
          end
          if (hwRxGood)
            nxt[`EPF_RXDONE] = ~isLinkedRx;
          if (isLinkedTx)
            nxt[`EPF_TXDONE] = 1'b0;
          if (isLinkedRx)
            nxt[`EPF_RXDONE] = 1'b0;
          epRegQ[g] <= nxt;
        end
      end
    end
  endgenerate

  assign globalTransferDoneIrq = |epIrq;

  // control registers
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rxUnlinkedDmaEnablesQ <= rxUnlkRst[`RX_UNLK_W-1:0];
      txUnlkQ <= `RST_TX_UNLK;
      linkCtrlQ <= `RST_LINK_CTRL;
    end else begin
      if (stateQ == ST_DATA && writeQ && addrQ == `OFS_RX_UNLK)
        rxUnlinkedDmaEnablesQ <= hwdata[`RX_UNLK_W-1:0];
      // completion clears after software write so hardware wins the same cycle
      if (rxLastAck && !rxLinkedModeEnable && rxDmaEp < `NUM_EP)
        rxUnlinkedDmaEnablesQ[rxDmaEp] <= 1'b0;
      // ids only change while the tx channel is idle
      if (stateQ == ST_DATA && writeQ && addrQ == `OFS_TX_UNLK) begin
        txUnlkQ[13:12] <= hwdata[13:12];
        if (!txBusyQ)
          txUnlkQ[11:0] <= hwdata[11:0];
      end
      if (stateQ == ST_DATA && writeQ && addrQ == `OFS_LINK_CTRL)
        linkCtrlQ <= {3'h0, hwdata[12:8], 3'h0, hwdata[4:0]};
    end
  end

  // token answers from the endpoint state fields
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tokAnswer <= `ANS_IGNORE;
      tokAnswerValid <= 1'b0;
      doubleBufSel <= 1'b0;
      statusOutSel <= 1'b0;
    end else begin
      tokAnswerValid <= tokStrobe & (tokEp < `NUM_EP);
      if (tokStrobe && tokEp < `NUM_EP) begin
        tokAnswer <= (tokIsIn | tokSetup) ?
                     answerOf(epRegQ[tokEp][`EPF_STAT_TX_LSB +: 2]) :
                     answerOf(epRegQ[tokEp][`EPF_STAT_RX_LSB +: 2]);
        doubleBufSel <= epRegQ[tokEp][`EPF_KIND] &
                        (epRegQ[tokEp][`EPF_TYPE_LSB +: 2] == `TYPE_BULK);
        statusOutSel <= epRegQ[tokEp][`EPF_KIND] &
                        (epRegQ[tokEp][`EPF_TYPE_LSB +: 2] == `TYPE_CTRL);
      end
    end
  end

  // rx channel: first enabled endpoint, linked overrides unlinked
  reg [3:0] rxPick;
  reg rxAny;
  always @* begin
    rxPick = 4'h0;
    rxAny = 1'b0;
    if (rxLinkedModeEnable) begin
      rxPick = rxLinkedEp;
      rxAny = 1'b1;
    end else begin
      for (i = `NUM_EP - 1; i >= 0; i = i - 1) begin
        if (rxUnlinkedDmaEnablesQ[i]) begin
          rxPick = i[3:0];
          rxAny = 1'b1;
        end
      end
    end
  end

  // busy spans one packet in unlinked mode, the whole chain in linked mode
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      txBusyQ <= 1'b0;
      rxBusyQ <= 1'b0;
      txDmaEp <= 4'h0;
      rxDmaEp <= 4'h0;
    end else begin
      if (!txBusyQ) begin
        txDmaEp <= txLinkedModeEnable ? txLinkedEp : txUnlkEp;
        if (txPktReady && (txLinkedModeEnable || txUnlkSel != 2'h0))
          txBusyQ <= 1'b1;
      end else if (txLinkedModeEnable ? txChainDone : txLastAck) begin
        txBusyQ <= 1'b0;
      end
      if (!rxBusyQ) begin
        rxDmaEp <= rxPick;
        if (rxPktReady && rxAny)
          rxBusyQ <= 1'b1;
      end else if (rxLinkedModeEnable ? rxChainDone : rxLastAck) begin
        rxBusyQ <= 1'b0;
      end
    end
  end

  // in linked mode the request may rest between packets of the chain
  assign txDmaReq = txBusyQ & (txPktReady | ~txLinkedModeEnable);
  assign rxDmaReq = rxBusyQ & (rxPktReady | ~rxLinkedModeEnable);

  // read mux; reserved rx bits read zero
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= 32'h00000000;
      if (haddr[11:0] == `OFS_RX_UNLK)
        hrdata <= {22'h000000, rxUnlinkedDmaEnablesQ};
      else if (haddr[11:0] == `OFS_TX_UNLK)
        hrdata <= {16'h0000, txUnlkQ};
      else if (haddr[11:0] == `OFS_LINK_CTRL)
        hrdata <= {16'h0000, linkCtrlQ};
      else if (haddr[11:0] == `OFS_DMA_STAT)
        hrdata <= {22'h000000, rxBusyQ, txBusyQ, rxDmaEp, txDmaEp};
      else if (haddr[11:0] >= `OFS_EP_BASE && haddr[11:0] <= `OFS_EP_LAST)
        hrdata <= {16'h0000, epRegQ[epIndex(haddr[11:0])]};
    end
  end
endmodule // usb_dma_if

/* tb/dma_chan_model.sv */
// one dma controller channel: acks packets on request, counts chain length
// assumes request level from usb_dma_if, clk_sys domain
`timescale 1ns/10ps
module dma_chan_model (
  input wire clk_sys, // clock
  input wire rst_n, // sync reset, active low
  input wire dmaReq, // channel request
  input wire [3:0] delay, // extra cycles per packet, slow or prompt
  input wire [3:0] chainPkts, // packets per descriptor chain
  output reg lastAck, // last word accepted, pulse
  output reg chainDone // terminal count, pulse
);
  reg [3:0] cnt_q;
  reg [3:0] pkt_q;
  always @(posedge clk_sys) begin
    lastAck <= 1'b0;
    chainDone <= 1'b0;
    if (!rst_n) begin
      cnt_q <= 4'h0;
      pkt_q <= 4'h0;
    end else if (dmaReq && !lastAck && !chainDone) begin
      // no ack while the request is still falling from the last one
      if (cnt_q == delay) begin
        cnt_q <= 4'h0;
        lastAck <= 1'b1;
        pkt_q <= pkt_q + 4'h1;
        if (pkt_q + 4'h1 == chainPkts) begin
          chainDone <= 1'b1;
          pkt_q <= 4'h0;
        end
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule // dma_chan_model

/* tb/usb_dma_if_assertions.sv */
// port assertions for usb_dma_if
// bound from tb; one clock domain, sync active-low reset
`timescale 1ns/10ps
module usb_dma_if_assertions (
  input wire clk_sys, // clock
  input wire rst_n, // sync reset
  input wire hsel, // slave select
  input wire [31:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire hready, // bus ready
  input wire hreadyout, // slave ready
  input wire hresp, // response
  input wire [31:0] hrdata, // read data
  input wire tokStrobe, // token event
  input wire [3:0] tokEp, // token endpoint
  input wire tokAnswerValid, // answer strobe
  input wire txPktReady, // tx packet ready
  input wire rxPktReady, // rx packet ready
  input wire txChainDone, // tx terminal count
  input wire rxChainDone, // rx terminal count
  input wire txDmaReq, // tx request
  input wire rxDmaReq, // rx request
  input wire [3:0] rxDmaEp // rx served endpoint
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  tok_answer_a: assert property (tokStrobe && tokEp < 4'ha |=> tokAnswerValid)
    else $error("token not answered");
  tok_refuse_a: assert property (tokStrobe && tokEp > 4'h9 |=> !tokAnswerValid)
    else $error("bad endpoint answered");
  answer_cause_a: assert property (tokAnswerValid |-> $past(tokStrobe))
    else $error("answer without token");
  rx_drop_a: assert property (rxDmaReq && rxChainDone |=> !rxDmaReq)
    else $error("rx request kept after end");
  tx_drop_a: assert property (txDmaReq && txChainDone |=> !txDmaReq)
    else $error("tx request kept after end");
  rx_rise_a: assert property ($rose(rxDmaReq) |-> $past(rxPktReady))
    else $error("rx request without packet");
  tx_rise_a: assert property ($rose(txDmaReq) |-> $past(txPktReady))
    else $error("tx request without packet");
  rx_ep_hold_a: assert property (rxDmaReq && $past(rxDmaReq) |-> $stable(rxDmaEp))
    else $error("rx endpoint changed mid transfer");
  rx_reserved_a: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr[11:0] == 12'h854 |=> hrdata[31:10] == 22'h0) else $error("reserved bits set");
endmodule // usb_dma_if_assertions

/* tb/tb.sv */
// testbench for usb_dma_if: token table, then register and dma cases
// drives ahb-lite and usb events; dma side answered by dma_chan_model
`timescale 1ns/10ps
module tb;
  typedef struct {logic [3:0] ep; logic [15:0] r; logic isIn; logic setup; logic [4:0] e;} row_t;
  logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans, tokAnswer;
  logic [2:0] hsize;
  logic tokStrobe, tokIsIn, tokSetup, xferGood, xferIsIn, tokAnswerValid, doubleBufSel;
  logic statusOutSel, txPktReady, rxPktReady, txLastAck, rxLastAck, txChainDone, rxChainDone;
  logic [3:0] tokEp, xferEp, txDmaEp, rxDmaEp, rxDelay, rxPkts;
  logic txDmaReq, rxDmaReq, globalTransferDoneIrq;
  int err_total = 0;
  int check_count = 0;
  int acks;
  row_t rows [10];
  usb_dma_if DUT (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tokStrobe, .tokIsIn, .tokSetup, .tokEp,
    .xferGood, .xferIsIn, .xferEp, .tokAnswer, .tokAnswerValid, .doubleBufSel, .statusOutSel,
    .txPktReady, .rxPktReady, .txLastAck, .rxLastAck, .txChainDone, .rxChainDone, .txDmaReq,
    .rxDmaReq, .txDmaEp, .rxDmaEp, .globalTransferDoneIrq);
  dma_chan_model txDma (.clk_sys, .rst_n, .dmaReq(txDmaReq), .delay(4'h1), .chainPkts(4'h1),
    .lastAck(txLastAck), .chainDone(txChainDone));
  dma_chan_model rxDma (.clk_sys, .rst_n, .dmaReq(rxDmaReq), .delay(rxDelay),
    .chainPkts(rxPkts), .lastAck(rxLastAck), .chainDone(rxChainDone));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task tok(input logic isIn, input logic setup, input logic [3:0] ep);
    @(posedge clk_sys);
    tokStrobe <= 1'b1;
    tokIsIn <= isIn;
    tokSetup <= setup;
    tokEp <= ep;
    @(posedge clk_sys);
    tokStrobe <= 1'b0;
    #1;
  endtask
  task good(input logic isIn, input logic [3:0] ep);
    @(posedge clk_sys);
    xferGood <= 1'b1;
    xferIsIn <= isIn;
    xferEp <= ep;
    @(posedge clk_sys);
    xferGood <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
  initial begin
    {hsel, hwrite, tokStrobe, tokIsIn, tokSetup, xferGood, xferIsIn, txPktReady, rxPktReady} = 9'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    tokEp = 4'h0;
    xferEp = 4'h0;
    rxDelay = 4'h3;
    rxPkts = 4'h1;
    rst_n = 1'b0;
    rows = '{'{4'h0, 16'h0000, 0, 0, 5'h10}, '{4'h1, 16'h1001, 0, 0, 5'h14},
      '{4'h2, 16'h2002, 0, 0, 5'h18}, '{4'h3, 16'h3103, 0, 0, 5'h1e},
      '{4'h4, 16'h0004, 1, 0, 5'h10}, '{4'h5, 16'h0015, 1, 0, 5'h14},
      '{4'h6, 16'h0226, 1, 1, 5'h18}, '{4'h7, 16'h0337, 1, 0, 5'h1d},
      '{4'h8, 16'h0538, 1, 0, 5'h1c}, '{4'h9, 16'h3709, 0, 0, 5'h1c}};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    ahb(1'b0, 12'h854, 32'h0);
    chk(v, 32'h0);
    foreach (rows[i]) begin
      ahb(1'b1, 12'h800 + {6'h0, rows[i].ep, 2'h0}, {16'h0, rows[i].r});
      ahb(1'b0, 12'h800 + {6'h0, rows[i].ep, 2'h0}, 32'h0);
      chk(v, {16'h0, rows[i].r});
      tok(rows[i].isIn, rows[i].setup, rows[i].ep);
      chk({tokAnswerValid, tokAnswer, doubleBufSel, statusOutSel}, rows[i].e);
    end
    tok(1'b0, 1'b0, 4'hc);
    chk(tokAnswerValid, 1'b0);
    ahb(1'b1, 12'h814, 32'h35);
    ahb(1'b0, 12'h814, 32'h0);
    chk(v, 32'h25);
    good(1'b1, 4'h7);
    ahb(1'b0, 12'h81c, 32'h0);
    chk(v[5:4], 2'h2);
    good(1'b1, 4'h8);
    ahb(1'b0, 12'h820, 32'h0);
    chk(v[5:4], 2'h3);
    ahb(1'b1, 12'h81c, 32'h0307);
    ahb(1'b1, 12'h820, 32'h0538);
    good(1'b0, 4'h3);
    chk(globalTransferDoneIrq, 1'b1);
    ahb(1'b1, 12'h80c, 32'h3103);
    #1 chk(globalTransferDoneIrq, 1'b0);
    ahb(1'b1, 12'h854, 32'hffff);
    ahb(1'b0, 12'h854, 32'h0);
    chk(v, 32'h3ff);
    ahb(1'b1, 12'h854, 32'h8);
    rxPktReady <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({rxDmaReq, rxDmaEp}, 5'h13);
    while (rxDmaReq !== 1'b0) @(posedge clk_sys);
    ahb(1'b0, 12'h854, 32'h0);
    chk(v, 32'h0);
    repeat (5) @(posedge clk_sys);
    #1 chk(rxDmaReq, 1'b0);
    rxPkts <= 4'h3;
    ahb(1'b1, 12'h85c, 32'h1300);
    acks = 0;
    repeat (2) @(posedge clk_sys);
    #1 chk({rxDmaReq, rxDmaEp}, 5'h19);
    while (rxDmaReq === 1'b1) begin
      @(posedge clk_sys);
      #1 acks += rxLastAck;
    end
    chk(acks, 3);
    rxPktReady <= 1'b0;
    good(1'b0, 4'h9);
    chk(globalTransferDoneIrq, 1'b0);
    ahb(1'b0, 12'h824, 32'h0);
    chk(v[15], 1'b0);
    ahb(1'b1, 12'h858, 32'h1004);
    txPktReady <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({txDmaReq, txDmaEp}, 5'h14);
    while (txDmaReq !== 1'b0) @(posedge clk_sys);
    txPktReady <= 1'b0;
    end_sim;
  end
endmodule // tb
bind usb_dma_if usb_dma_if_assertions chkr (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .tokStrobe, .tokEp, .tokAnswerValid, .txPktReady,
  .rxPktReady, .txChainDone, .rxChainDone, .txDmaReq, .rxDmaReq, .rxDmaEp);
